// >>> hw/aare_regs.svh
// Register map, field positions and timing figures of the ack / retransmit engine.
// Assumes a 32-bit AXI4-Lite slave; each register index sits at byte address index*4.
//
// Notes on behaviour
// - Auto-ack only when auto-ack bit is one.
// - Transmit ack-request inverse bit as no-ack field.
// - Missing ack: packet lost, no data-sent event.
// - Ack echoes source, local address, same sequence.
// - Piggyback plus queued data: data becomes ack payload.
// - Otherwise send empty ack, addresses and sequence.
// - Queue read per ack; empty gives underflow.
// - Every ack carries no-ack flag set.
// - Ack valid: not timed out, unfiltered, sequence matches.
// - Auto-ack only in link-layer-stack packet format.
// - Repeated packet: ack again, same piggyback payload.
// - Retry limit 0..15, zero disables retransmission.
// - Attempt count readable, at most limit plus one.
// - Limit reached: event raised, queue kept intact (code raises no event when the limit is zero).
// - Retries replay same queue contents, no refill.
// - Receive timer: fdig/1210, ((p+1)*c-1) ticks.
// - Wake-up timer: RC scaled 1..8, (p+1)*(c+1).
// - Sniff timer: settle limit ticks, filter exponent rate.
`ifndef AARE_REGS_SVH
`define AARE_REGS_SVH

// Register indices (byte address = index * 4)
`define AARE_IDX_RX_TIMEOUT_COUNT 8'h46
`define AARE_IDX_RX_TIMEOUT_PRESCALE 8'h47
`define AARE_IDX_WAKEUP_PRESCALE 8'h48
`define AARE_IDX_WAKEUP_COUNT 8'h49
`define AARE_IDX_WAKEUP_RELOAD_PRESCALE 8'h4a
`define AARE_IDX_WAKEUP_RELOAD_COUNT 8'h4b
`define AARE_IDX_SNIFF_SETTLE_LIMIT 8'h54
`define AARE_IDX_CONTROL 8'h60
`define AARE_IDX_COMMAND 8'h61
`define AARE_IDX_STATUS 8'h62
`define AARE_IDX_ADDRESS 8'h63

// Control register fields
`define AARE_CTL_AUTO_ACK 0
`define AARE_CTL_PIGGYBACK 1
`define AARE_CTL_ACK_REQ_INV 2
`define AARE_CTL_STACK_FMT 3
`define AARE_CTL_RETRY_LO 4
`define AARE_CTL_RETRY_HI 7
`define AARE_CTL_WU_SCALE_LO 8
`define AARE_CTL_WU_SCALE_HI 9
`define AARE_CTL_WU_EN 10
`define AARE_CTL_CHF_EXP_LO 11
`define AARE_CTL_CHF_EXP_HI 13
`define AARE_CTL_RESET 16'h0000
`define AARE_CTL_WIDTH 16

// Command register bits (write one to act)
`define AARE_CMD_TX 0
`define AARE_CMD_RX 1
`define AARE_CMD_FLUSH 2
`define AARE_CMD_WU_RELOAD 3

// Status register fields
`define AARE_STS_ATTEMPT_LO 0
`define AARE_STS_ATTEMPT_HI 4
`define AARE_STS_UNDERFLOW 5
`define AARE_STS_BUSY 6

// Timing figures
`define AARE_RX_TICK_DIV 11'd1210
`define AARE_SNIFF_DIV 6'd24
`define AARE_BYTE_RESET 8'h00
`define AARE_RESP_OKAY 2'b00
`define AARE_RESP_SLVERR 2'b10

`endif

// >>> hw/aare_pkg.sv
// Types shared by the ack / retransmit engine.
// Assumes aare_regs.svh supplies the numeric constants.
package aare_pkg;
    typedef enum logic [2:0] {
        AARE_IDLE,
        AARE_SEND_DATA,
        AARE_WAIT_ACK,
        AARE_LISTEN,
        AARE_SEND_ACK
    } aare_state_e;
    typedef logic [7:0] aare_byte_t;
    typedef logic [11:0] aare_addr_t;
endpackage

// >>> hw/aare_engine.sv
// Link-layer ack / retransmit engine with receive, wake-up and sniff timers.
// Assumes a packet framer that sends on tx_start and reports received headers,
// and a transmit queue that can be read, replayed from its start and flushed.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "aare_regs.svh"

module aare_engine (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // AXI4-Lite slave
    input wire aare_pkg::aare_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire aare_pkg::aare_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Framer transmit request
    output logic tx_start_r,
    output logic tx_no_ack_r,
    output logic tx_payload_en_r,
    output aare_pkg::aare_byte_t tx_dest_r,
    output aare_pkg::aare_byte_t tx_src_r,
    output aare_pkg::aare_byte_t tx_seq_r,
    input wire logic tx_done,
    // Framer receive report
    output logic rx_active_r,
    input wire logic rx_pkt_valid,
    input wire logic rx_filtered,
    input wire logic rx_no_ack,
    input wire aare_pkg::aare_byte_t rx_src,
    input wire aare_pkg::aare_byte_t rx_seq,
    // Transmit queue
    input wire logic txq_empty,
    output logic txq_read_r,
    output logic txq_rewind_r,
    output logic txq_flush_r,
    // Events
    output logic data_sent_r,
    output logic retry_limit_reached_interrupt,
    output logic rx_timeout_r,
    // Timers
    input wire logic rco_tick,
    output logic wakeup_r,
    input wire logic sniff_start,
    output logic sniff_expired_r
);
    import aare_pkg::*;

    aare_state_e state_r;
    logic [`AARE_CTL_WIDTH-1:0] ctl_r;
    aare_byte_t rxt_count_r, rxt_pre_r, wu_pre_r, wu_cnt_r, wu_rpre_r, wu_rcnt_r, sniff_lim_r;
    aare_byte_t local_src_r, seq_r;
    logic [4:0] attempt_r;
    logic underflow_r;
    logic [3:0] cmd_r;
    logic [3:0] retry_limit;
    logic aw_hold_r, w_hold_r;
    aare_addr_t aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire, wr_hit;
    aare_byte_t wr_idx, rd_idx;
    logic [31:0] rd_val;
    logic rd_hit;
    logic rx_expire;

    assign retry_limit = ctl_r[`AARE_CTL_RETRY_HI:`AARE_CTL_RETRY_LO];

    // Write path: address and data taken in either order, answered together
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_idx = aw_addr_r[9:2];
    assign rd_idx = s_axi_araddr[9:2];
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `AARE_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `AARE_RESP_OKAY : `AARE_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Ready flags registered so outputs come from flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
            s_axi_wready <= !w_hold_r && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
        end
    end

    // Address decode for writes
    always_comb begin
        unique case (wr_idx)
            `AARE_IDX_RX_TIMEOUT_COUNT, `AARE_IDX_RX_TIMEOUT_PRESCALE, `AARE_IDX_WAKEUP_PRESCALE,
            `AARE_IDX_WAKEUP_COUNT, `AARE_IDX_WAKEUP_RELOAD_PRESCALE, `AARE_IDX_WAKEUP_RELOAD_COUNT,
            `AARE_IDX_SNIFF_SETTLE_LIMIT, `AARE_IDX_CONTROL, `AARE_IDX_COMMAND, `AARE_IDX_STATUS,
            `AARE_IDX_ADDRESS: wr_hit = (aw_addr_r[11:10] == 2'b00);
            default: wr_hit = 1'b0;
        endcase
    end

    // Configuration registers, byte lanes honoured
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_r <= `AARE_CTL_RESET;
            rxt_count_r <= `AARE_BYTE_RESET;
            rxt_pre_r <= `AARE_BYTE_RESET;
            wu_rpre_r <= `AARE_BYTE_RESET;
            wu_rcnt_r <= `AARE_BYTE_RESET;
            sniff_lim_r <= `AARE_BYTE_RESET;
            local_src_r <= `AARE_BYTE_RESET;
            seq_r <= `AARE_BYTE_RESET;
            cmd_r <= '0;
        end else if (clk_en) begin
            cmd_r <= '0;
            if (wr_fire && wr_hit && w_strb_r[0]) begin
                unique case (wr_idx)
                    `AARE_IDX_RX_TIMEOUT_COUNT: rxt_count_r <= w_data_r[7:0];
                    `AARE_IDX_RX_TIMEOUT_PRESCALE: rxt_pre_r <= w_data_r[7:0];
                    `AARE_IDX_WAKEUP_RELOAD_PRESCALE: wu_rpre_r <= w_data_r[7:0];
                    `AARE_IDX_WAKEUP_RELOAD_COUNT: wu_rcnt_r <= w_data_r[7:0];
                    `AARE_IDX_SNIFF_SETTLE_LIMIT: sniff_lim_r <= w_data_r[7:0];
                    `AARE_IDX_CONTROL: ctl_r[7:0] <= w_data_r[7:0];
                    `AARE_IDX_COMMAND: cmd_r <= w_data_r[3:0];
                    `AARE_IDX_ADDRESS: local_src_r <= w_data_r[7:0];
                    default: ;
                endcase
            end
            if (wr_fire && wr_hit && w_strb_r[1]) begin
                if (wr_idx == `AARE_IDX_CONTROL) ctl_r[15:8] <= w_data_r[15:8];
                if (wr_idx == `AARE_IDX_ADDRESS) seq_r <= w_data_r[15:8];
            end
        end
    end

    // Read path: one cycle from address to data
    always_comb begin
        rd_hit = (s_axi_araddr[11:10] == 2'b00);
        unique case (rd_idx)
            `AARE_IDX_RX_TIMEOUT_COUNT: rd_val = {24'h0, rxt_count_r};
            `AARE_IDX_RX_TIMEOUT_PRESCALE: rd_val = {24'h0, rxt_pre_r};
            `AARE_IDX_WAKEUP_PRESCALE: rd_val = {24'h0, wu_pre_r};
            `AARE_IDX_WAKEUP_COUNT: rd_val = {24'h0, wu_cnt_r};
            `AARE_IDX_WAKEUP_RELOAD_PRESCALE: rd_val = {24'h0, wu_rpre_r};
            `AARE_IDX_WAKEUP_RELOAD_COUNT: rd_val = {24'h0, wu_rcnt_r};
            `AARE_IDX_SNIFF_SETTLE_LIMIT: rd_val = {24'h0, sniff_lim_r};
            `AARE_IDX_CONTROL: rd_val = {16'h0, ctl_r};
            `AARE_IDX_COMMAND: rd_val = 32'h0;
            `AARE_IDX_STATUS: rd_val = {25'h0, state_r != AARE_IDLE, underflow_r, attempt_r};
            `AARE_IDX_ADDRESS: rd_val = {16'h0, seq_r, local_src_r};
            default: begin
                rd_val = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `AARE_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_hit ? `AARE_RESP_OKAY : `AARE_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Receive timer: tick every 1210 clocks, runs while listening
    logic [10:0] rxt_div_r;
    logic [15:0] rxt_left_r;
    logic rxt_load, rxt_inf_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxt_div_r <= '0;
            rxt_left_r <= '0;
            rxt_inf_r <= 1'b0;
            rx_timeout_r <= 1'b0;
        end else if (clk_en) begin
            rx_timeout_r <= rx_expire;
            if (rxt_load) begin
                rxt_div_r <= '0;
                rxt_inf_r <= (rxt_count_r == 8'h00);
                rxt_left_r <= 16'(({8'h00, rxt_pre_r} + 16'h0001) * {8'h00, rxt_count_r} - 16'h0001);
            end else if (rx_active_r && !rxt_inf_r) begin
                rxt_div_r <= (rxt_div_r == `AARE_RX_TICK_DIV - 11'd1) ? 11'd0 : rxt_div_r + 11'd1;
                if (rxt_div_r == `AARE_RX_TICK_DIV - 11'd1 && rxt_left_r != 16'h0000)
                    rxt_left_r <= rxt_left_r - 16'h0001;
            end
        end
    end
    assign rx_expire = rx_active_r && !rxt_inf_r && !rxt_load &&
        rxt_div_r == `AARE_RX_TICK_DIV - 11'd1 && rxt_left_r <= 16'h0001;

    // Protocol sequencer
    logic ack_ok, ack_wanted, retry_left;
    assign ack_ok = rx_pkt_valid && !rx_filtered && !rx_expire && rx_seq == seq_r;
    assign ack_wanted = ctl_r[`AARE_CTL_AUTO_ACK] && ctl_r[`AARE_CTL_STACK_FMT] && !rx_no_ack;
    assign retry_left = retry_limit != 4'h0 && attempt_r <= {1'b0, retry_limit};
    assign rxt_load = clk_en && ((state_r == AARE_SEND_DATA && tx_done && !tx_no_ack_r) ||
        (state_r == AARE_IDLE && cmd_r[`AARE_CMD_RX]) || (state_r == AARE_SEND_ACK && tx_done));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= AARE_IDLE;
            attempt_r <= '0;
            tx_start_r <= 1'b0;
            tx_no_ack_r <= 1'b0;
            tx_payload_en_r <= 1'b0;
            tx_dest_r <= '0;
            tx_src_r <= '0;
            tx_seq_r <= '0;
            rx_active_r <= 1'b0;
            txq_read_r <= 1'b0;
            txq_rewind_r <= 1'b0;
            data_sent_r <= 1'b0;
            retry_limit_reached_interrupt <= 1'b0;
        end else if (clk_en) begin
            tx_start_r <= 1'b0;
            txq_read_r <= 1'b0;
            txq_rewind_r <= 1'b0;
            data_sent_r <= 1'b0;
            retry_limit_reached_interrupt <= 1'b0;
            unique case (state_r)
                AARE_IDLE: begin
                    if (cmd_r[`AARE_CMD_TX]) begin
                        state_r <= AARE_SEND_DATA;
                        attempt_r <= 5'd1;
                        tx_start_r <= 1'b1;
                        tx_no_ack_r <= ctl_r[`AARE_CTL_ACK_REQ_INV];
                        tx_payload_en_r <= 1'b1;
                        tx_dest_r <= '0;
                        tx_src_r <= local_src_r;
                        tx_seq_r <= seq_r;
                    end else if (cmd_r[`AARE_CMD_RX]) begin
                        state_r <= AARE_LISTEN;
                        rx_active_r <= 1'b1;
                    end
                end
                AARE_SEND_DATA: begin
                    if (tx_done && tx_no_ack_r) begin
                        state_r <= AARE_IDLE;
                        data_sent_r <= 1'b1;
                    end else if (tx_done) begin
                        state_r <= AARE_WAIT_ACK;
                        rx_active_r <= 1'b1;
                    end
                end
                AARE_WAIT_ACK: begin
                    if (ack_ok) begin
                        state_r <= AARE_IDLE;
                        rx_active_r <= 1'b0;
                        data_sent_r <= 1'b1;
                    end else if (rx_expire && retry_left) begin
                        state_r <= AARE_SEND_DATA;
                        rx_active_r <= 1'b0;
                        attempt_r <= attempt_r + 5'd1;
                        txq_rewind_r <= 1'b1;
                        tx_start_r <= 1'b1;
                    end else if (rx_expire) begin
                        state_r <= AARE_IDLE;
                        rx_active_r <= 1'b0;
                        retry_limit_reached_interrupt <= retry_limit != 4'h0;
                    end
                end
                AARE_LISTEN: begin
                    if (rx_expire) begin
                        state_r <= AARE_IDLE;
                        rx_active_r <= 1'b0;
                    end else if (rx_pkt_valid && !rx_filtered && ack_wanted) begin
                        state_r <= AARE_SEND_ACK;
                        rx_active_r <= 1'b0;
                        tx_start_r <= 1'b1;
                        tx_dest_r <= rx_src;
                        tx_src_r <= local_src_r;
                        tx_seq_r <= rx_seq;
                        tx_no_ack_r <= 1'b1;
                        tx_payload_en_r <= ctl_r[`AARE_CTL_PIGGYBACK] && !txq_empty;
                        txq_read_r <= 1'b1;
                    end
                end
                AARE_SEND_ACK: begin
                    if (tx_done) begin
                        state_r <= AARE_LISTEN;
                        rx_active_r <= 1'b1;
                        txq_rewind_r <= tx_payload_en_r;
                    end
                end
            endcase
        end
    end

    // Underflow flag: ack queue read on empty, cleared by flush, set wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            underflow_r <= 1'b0;
            txq_flush_r <= 1'b0;
        end else if (clk_en) begin
            txq_flush_r <= cmd_r[`AARE_CMD_FLUSH];
            if (txq_read_r && txq_empty)
                underflow_r <= 1'b1;
            else if (cmd_r[`AARE_CMD_FLUSH])
                underflow_r <= 1'b0;
        end
    end

    // Wake-up timer on scaled RC ticks, period (p+1)*(c+1)
    logic [2:0] wu_scale_r;
    logic [2:0] wu_scale_max;
    logic wu_tick;
    assign wu_scale_max = 3'((4'h1 << ctl_r[`AARE_CTL_WU_SCALE_HI:`AARE_CTL_WU_SCALE_LO]) - 4'h1);
    assign wu_tick = rco_tick && wu_scale_r == wu_scale_max;
    aare_byte_t wu_pcur_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wu_scale_r <= '0;
            wu_pre_r <= `AARE_BYTE_RESET;
            wu_cnt_r <= `AARE_BYTE_RESET;
            wu_pcur_r <= '0;
            wakeup_r <= 1'b0;
        end else if (clk_en) begin
            wakeup_r <= 1'b0;
            if (wr_fire && wr_hit && w_strb_r[0] && wr_idx == `AARE_IDX_WAKEUP_PRESCALE) begin
                wu_pre_r <= w_data_r[7:0];
                wu_pcur_r <= w_data_r[7:0];
            end else if (wr_fire && wr_hit && w_strb_r[0] && wr_idx == `AARE_IDX_WAKEUP_COUNT) begin
                wu_cnt_r <= w_data_r[7:0];
            end else if (cmd_r[`AARE_CMD_WU_RELOAD]) begin
                wu_pre_r <= wu_rpre_r;
                wu_pcur_r <= wu_rpre_r;
                wu_cnt_r <= wu_rcnt_r;
            end else if (ctl_r[`AARE_CTL_WU_EN] && rco_tick) begin
                wu_scale_r <= wu_tick ? 3'd0 : wu_scale_r + 3'd1;
                if (wu_tick && wu_pcur_r != 8'h00) begin
                    wu_pcur_r <= wu_pcur_r - 8'h01;
                end else if (wu_tick) begin
                    wu_pcur_r <= wu_pre_r;
                    if (wu_cnt_r == 8'h00) begin
                        wakeup_r <= 1'b1;
                        wu_cnt_r <= wu_rcnt_r;
                        wu_pre_r <= wu_rpre_r;
                        wu_pcur_r <= wu_rpre_r;
                    end else begin
                        wu_cnt_r <= wu_cnt_r - 8'h01;
                    end
                end
            end
        end
    end

    // Sniff timer: source rate fdig/24 * 2^exponent by accumulator, for exponents 0 to 4
    logic [5:0] sn_acc_r;
    logic [6:0] sn_sum;
    aare_byte_t sn_left_r;
    logic sn_run_r;
    assign sn_sum = {1'b0, sn_acc_r} + 7'(7'h01 << ctl_r[`AARE_CTL_CHF_EXP_HI:`AARE_CTL_CHF_EXP_LO]);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sn_acc_r <= '0;
            sn_left_r <= '0;
            sn_run_r <= 1'b0;
            sniff_expired_r <= 1'b0;
        end else if (clk_en) begin
            sniff_expired_r <= 1'b0;
            if (sniff_start) begin
                sn_acc_r <= '0;
                sn_left_r <= sniff_lim_r;
                sn_run_r <= 1'b1;
            end else if (sn_run_r && sn_sum >= {1'b0, `AARE_SNIFF_DIV}) begin
                sn_acc_r <= 6'(sn_sum - {1'b0, `AARE_SNIFF_DIV});
                if (sn_left_r <= 8'h01) begin
                    sn_run_r <= 1'b0;
                    sniff_expired_r <= 1'b1;
                end else begin
                    sn_left_r <= sn_left_r - 8'h01;
                end
            end else if (sn_run_r) begin
                sn_acc_r <= sn_sum[5:0];
            end
        end
    end

endmodule // aare_engine

// >>> tb/aare_engine_asserts.sv
// Checker on the engine's send, ack and event outputs.
// Assumes binding onto aare_engine; sees its ports only.
`timescale 1ns/1ps
module aare_engine_asserts (
    // Clock, reset, framer and queue side
    input wire logic sys_clk, arst_n, tx_start_r, tx_no_ack_r, tx_payload_en_r, tx_done, rx_active_r,
    input wire aare_pkg::aare_byte_t tx_seq_r, rx_seq,
    input wire logic rx_pkt_valid, txq_empty, txq_read_r, txq_flush_r, data_sent_r, retry_limit_reached_interrupt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_ack_pair: assert property (txq_read_r |-> tx_start_r) else $error("lone read");
    a_ack_cause: assert property (txq_read_r |-> $past(rx_pkt_valid)) else $error("no packet");
    a_ack_no_ack: assert property (txq_read_r |-> tx_no_ack_r) else $error("ack asks ack");
    a_ack_empty: assert property (txq_read_r && $past(txq_empty) |-> !tx_payload_en_r) else $error("payload");
    a_wait_rx: assert property (tx_done && !tx_no_ack_r |=> rx_active_r) else $error("no listen");
    a_sent_seq: assert property (data_sent_r && $past(rx_pkt_valid) |-> $past(rx_seq) == tx_seq_r)
        else $error("bad seq");
    a_limit_keep: assert property (retry_limit_reached_interrupt |-> !txq_flush_r [*2]) else $error("flush");
    a_limit_quiet: assert property (retry_limit_reached_interrupt |-> !data_sent_r) else $error("sent");
    c_limit: cover property (retry_limit_reached_interrupt);
    c_sent: cover property (data_sent_r && $past(rx_pkt_valid));
    c_piggy: cover property (txq_read_r && tx_payload_en_r);
endmodule // aare_engine_asserts
bind aare_engine aare_engine_asserts aare_engine_asserts_inst (.*);

// >>> tb/aare_peer_model.sv
// Peer and framer model: finishes each send and answers ack requests.
// Assumes the bench sets the answer kind and injects packets.
`timescale 1ns/1ps
module aare_peer_model (
    // Clock, reset, requests, control (answer 0 none, 1 ack, 2 wrong sequence)
    input wire logic sys_clk, arst_n, tx_start_r, tx_no_ack_r, inj,
    input wire logic [1:0] answer,
    input wire aare_pkg::aare_byte_t tx_seq_r, inj_src, inj_seq,
    // Replies
    output logic tx_done, rx_pkt_valid, rx_filtered, rx_no_ack,
    output aare_pkg::aare_byte_t rx_src, rx_seq
);
    import aare_pkg::*;
    aare_byte_t q;
    logic [1:0] k;
    // One-cycle report; source and sequence inverted once released
    task automatic pkt(input aare_byte_t s, input aare_byte_t n, input logic a);
        {rx_pkt_valid, rx_no_ack, rx_src, rx_seq} <= {1'b1, a, s, n};
        @(posedge sys_clk);
        {rx_pkt_valid, rx_src, rx_seq} <= {1'b0, ~s, ~n};
    endtask
    // Quiet lines at start
    initial {tx_done, rx_pkt_valid, rx_filtered, rx_no_ack, rx_src, rx_seq} = '0;
    // Send takes five cycles, a requested answer six more
    always @(posedge sys_clk) begin
        if (arst_n && tx_start_r) begin
            q = tx_seq_r;
            k = tx_no_ack_r ? 2'd0 : answer;
            repeat (4) @(posedge sys_clk);
            tx_done <= 1'b1;
            @(posedge sys_clk);
            tx_done <= 1'b0;
            repeat (6) @(posedge sys_clk);
            if (k != 2'd0) pkt(8'hc3, q + {7'h0, k == 2'd2}, 1'b1);
        end else if (inj) pkt(inj_src, inj_seq, 1'b0);
    end
endmodule // aare_peer_model

// >>> tb/auto_ack_retransmit_engine_tb_top.sv
// Bench: registers, retries, ack acceptance and automatic acks.
// Assumes the peer model and the bound checker.
`timescale 1ns/1ps
module auto_ack_retransmit_engine_tb_top;
    import aare_pkg::*;
    logic sys_clk, arst_n, clk_en, rco_tick, sniff_start, wakeup_r, sniff_expired_r, inj, tx_start_r, tx_no_ack_r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_payload_en_r, tx_done, rx_active_r, rx_pkt_valid;
    logic rx_filtered, rx_no_ack, txq_empty, txq_read_r, txq_rewind_r, txq_flush_r, data_sent_r, rx_timeout_r;
    logic retry_limit_reached_interrupt;
    aare_addr_t s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rs;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, answer;
    aare_byte_t tx_dest_r, tx_src_r, tx_seq_r, rx_src, rx_seq, inj_src, inj_seq, loc;
    logic [26:0] expq[$], e, s;
    logic [8:0] tbl[6] = '{9'h00b, 9'h00b, 9'h009, 9'h10b, 9'h00a, 9'h003};
    int checked = 0, bad_count = 0, sent_n = 0, rew_n = 0;
    aare_engine aare_engine_inst (.*);
    aare_peer_model aare_peer_model_inst (.*);
    // Clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] v, input logic [31:0] x);
        checked++;
        if (v !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, v);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One register access; w selects write, reads compared under mask m
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [31:0] m);
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {2'b00, i, 4'h0, i, 2'b00, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {{3{w}}, {2{!w}}};
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        chk("resp", w ? s_axi_bresp : s_axi_rresp, (i == 8'h7f) ? 2'b10 : 2'b00);
        if (!w) chk("rdata", s_axi_rdata & m, d);
    endtask
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Event counts; each send compared with the oldest note
    always @(posedge sys_clk) begin
        if (data_sent_r === 1'b1) sent_n++;
        if (txq_rewind_r === 1'b1) rew_n++;
        if (tx_start_r === 1'b1 && expq.size() == 0) chk("spare send", 1, 0);
        else if (tx_start_r === 1'b1) begin
            e = expq.pop_front();
            s = {e[26], tx_no_ack_r, tx_payload_en_r, tx_dest_r, tx_src_r, tx_seq_r};
            chk("send", s & (e[26] ? 27'h7ffffff : 27'h600ffff), e);
        end
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        test_done;
    end
    // Main sequence
    initial begin
        {arst_n, rco_tick, sniff_start, inj, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, answer, inj_src, inj_seq, txq_empty} = '0;
        {clk_en, s_axi_wstrb, rs} = {1'b1, 4'hf, 32'h38f9};
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        bus(1'b1, 8'h54, 32'h5a, '1);
        bus(1'b0, 8'h54, 32'h5a, '1);
        bus(1'b0, 8'h7f, 32'h0, '1);
        rs = nx(rs);
        loc = rs[7:0];
        bus(1'b1, 8'h63, {16'h0, rs[15:0]}, '1);
        bus(1'b1, 8'h46, 32'h1, '1);
        answer <= 2'd2;
        bus(1'b1, 8'h60, 32'h20, '1);
        repeat (3) expq.push_back({11'h0, loc, rs[15:8]});
        bus(1'b1, 8'h61, 32'h1, '1);
        while (retry_limit_reached_interrupt !== 1'b1) @(posedge sys_clk);
        bus(1'b0, 8'h62, 32'h3, 32'h1f);
        chk("sent", sent_n, 0);
        chk("rewinds", rew_n, 2);
        answer <= 2'd1;
        expq.push_back({11'h0, loc, rs[15:8]});
        bus(1'b1, 8'h61, 32'h1, '1);
        while (sent_n == 0) @(posedge sys_clk);
        bus(1'b0, 8'h62, 32'h1, 32'h1f);
        // Listen, no timeout
        answer <= 2'd0;
        bus(1'b1, 8'h46, 32'h0, '1);
        foreach (tbl[j]) begin
            bus(1'b1, 8'h60, {24'h0, tbl[j][7:0]}, '1);
            if (j == 0) bus(1'b1, 8'h61, 32'h2, '1);
            txq_empty <= tbl[j][8];
            if (j != 1) rs = nx(rs);
            if (tbl[j][0] & tbl[j][3]) expq.push_back({2'b11, tbl[j][1] & !tbl[j][8], rs[15:8], loc, rs[7:0]});
            {inj, inj_src, inj_seq} <= {1'b1, rs[15:0]};
            @(posedge sys_clk);
            inj <= 1'b0;
            repeat (20) @(posedge sys_clk);
        end
        bus(1'b0, 8'h62, 32'h20, 32'h20);
        bus(1'b1, 8'h61, 32'h4, '1);
        bus(1'b0, 8'h62, 32'h0, 32'h20);
        chk("notes left", expq.size(), 0);
        test_done;
    end
endmodule // auto_ack_retransmit_engine_tb_top
